/* File: inc/ums_map.svh */
// Notes on behaviour
// - Transfers run only while the transmitter is enabled; otherwise no clocking happens.
// - Enabled transmitter takes the serial output pin from its port function.
// - Receiver is optional; when enabled in SPI mode it takes the serial input pin.
// - The transfer clock pin is the serial clock whenever the transmitter runs.
// - Only a data register write starts an exchange, for receive too.
// - Written byte waits in transmit buffer, then moves to free shift register.
// - On receive overflow the newest byte is dropped, older bytes kept.
// - Master SPI operation only when both mode-select bits are one.
// - Frames are eight bits, order set by one shared bit-order setting.
// - Frame, overrun and parity error flags always read zero.
// - Transmitter disable waits until shift register and buffer are empty.
`ifndef UMS_MAP_SVH
`define UMS_MAP_SVH

// ==========================================================================
// Modes and frame format.
`define UMS_MODE_SPI      2'h3
`define UMS_ORDER_LSB     1'h1
`define UMS_FRAME_BITS    8
`define UMS_HALF_LAST     4'hf

// ==========================================================================
// Sizes and reset values.
`define UMS_DIV_W         12
`define UMS_DIV_RESET     12'h000
`define UMS_RX_DEPTH      8
`define UMS_BYTE_RESET    8'h00

`endif

/* File: inc/ums_pkg.sv */
`include "ums_map.svh"

package ums_pkg;

  // ==========================================================================
  // Control settings as software holds them.
  typedef struct packed {
    logic [1:0] mode_select;
    logic       transmitter_enable;
    logic       receiver_enable;
    logic       bit_order_select;
    logic       clock_phase_select;
    logic       clock_polarity_select;
  } ums_ctrl_t;

  // ==========================================================================
  // Status flags as software reads them.
  typedef struct packed {
    logic receive_complete_flag;
    logic transmit_complete_flag;
    logic data_empty_flag;
    logic frame_error_flag;
    logic overrun_flag;
    logic parity_error_flag;
  } ums_status_t;

  // ==========================================================================
  // Transfer sequencer states.
  typedef enum logic [2:0] {
    UMS_ST_IDLE  = 3'b001,
    UMS_ST_SHIFT = 3'b010,
    UMS_ST_DONE  = 3'b100
  } ums_state_t;

endpackage : ums_pkg

/* File: core/ums_fifo.sv */
`timescale 1ns/10ps
`include "ums_map.svh"

module ums_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `UMS_RX_DEPTH
) (
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_q != (AW+1)'(DEPTH));
  assign out_valid_out = (count_q != '0);
  assign out_data_out  = mem_q[rd_ptr_q];
  assign push          = in_valid_in && in_ready_out && !flush_in;
  assign pop           = out_valid_out && out_ready_in && !flush_in;

  // ==========================================================================
  // Storage has no reset; only the pointers define what is valid.
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  // ==========================================================================
  // Pointers and fill level.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (flush_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + (AW+1)'(1);
      end else if (pop && !push) begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end

endmodule : ums_fifo

/* File: core/ums_baud.sv */
`timescale 1ns/10ps
`include "ums_map.svh"

module ums_baud #(
  parameter int DIV_W = `UMS_DIV_W
) (
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  input  wire logic             run_in,
  input  wire logic [DIV_W-1:0] divisor_in,
  output logic                  tick_out
);

  logic [DIV_W-1:0] count_q;

  // ==========================================================================
  // One tick every divisor plus one cycles marks each half period of the
  // transfer clock. Holding the counter at zero while stopped makes the
  // first half period after a start always full length.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_q  <= '0;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      count_q  <= '0;
      tick_out <= 1'b0;
    end else if (count_q >= divisor_in) begin
      count_q  <= '0;
      tick_out <= 1'b1;
    end else begin
      count_q  <= count_q + DIV_W'(1);
      tick_out <= 1'b0;
    end
  end

endmodule : ums_baud

/* File: core/ums_spi_master.sv */
`timescale 1ns/10ps
`include "ums_map.svh"

module ums_spi_master
  import ums_pkg::*;
#(
  parameter int DIV_W    = `UMS_DIV_W,
  parameter int RX_DEPTH = `UMS_RX_DEPTH
) (
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  input  wire ums_ctrl_t        control_in,
  input  wire logic [DIV_W-1:0] baud_divisor_in,
  input  wire logic             data_wr_in,
  input  wire logic [7:0]       data_wr_byte_in,
  input  wire logic             data_rd_in,
  input  wire logic             tx_complete_clr_in,
  input  wire logic             port_out_value_in,
  input  wire logic             port_out_oe_in,
  input  wire logic             serial_in_pin_in,
  output logic [7:0]            data_rd_byte_out,
  output ums_status_t           status_out,
  output logic                  serial_out_pin_out,
  output logic                  serial_out_pin_oe_out,
  output logic                  transfer_clock_pin_out,
  output logic                  transfer_clock_pin_oe_out,
  output logic                  serial_in_override_out
);

  // ==========================================================================
  // Internal signals.
  ums_state_t  state_q;
  logic        tx_on_q;
  logic        spi_mode;
  logic        run;
  logic [7:0]  txbuf_q;
  logic        txbuf_full_q;
  logic [7:0]  shift_q;
  logic [7:0]  rx_shift_q;
  logic [3:0]  half_q;
  logic        sck_q;
  logic        mosi_q;
  logic        rxc_q;
  logic        txc_q;
  logic        udre_q;
  logic [7:0]  rd_byte_q;
  logic        sin_meta_q;
  logic        sin_sync_q;
  logic        tick;
  logic        leading;
  logic        setup_now;
  logic        sample_now;
  logic        frame_end;
  logic        load_now;
  logic        wr_take;
  logic        rx_push;
  logic        rx_ready;
  logic        rx_valid;
  logic [7:0]  rx_head;
  logic        rx_pop;
  logic        rx_flush;
  logic        lsb_first;

  // ==========================================================================
  // Mode decode and transmitter ownership.
  assign spi_mode  = (control_in.mode_select == `UMS_MODE_SPI);
  assign lsb_first = (control_in.bit_order_select == `UMS_ORDER_LSB);

  // A disable is only honoured once nothing is left to send, so a byte that
  // software has already queued is never cut off mid-frame.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_on_q <= 1'b0;
    end else if (control_in.transmitter_enable && spi_mode) begin
      tx_on_q <= 1'b1;
    end else if (state_q == UMS_ST_IDLE && !txbuf_full_q) begin
      tx_on_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Input pin synchroniser.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sin_meta_q <= 1'b0;
      sin_sync_q <= 1'b0;
    end else begin
      sin_meta_q <= serial_in_pin_in;
      sin_sync_q <= sin_meta_q;
    end
  end

  // ==========================================================================
  // Transmit buffer.
  assign wr_take  = data_wr_in && tx_on_q && !txbuf_full_q;
  assign load_now = (state_q == UMS_ST_IDLE) && txbuf_full_q && tx_on_q;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      txbuf_q      <= `UMS_BYTE_RESET;
      txbuf_full_q <= 1'b0;
    end else if (wr_take) begin
      txbuf_q      <= data_wr_byte_in;
      txbuf_full_q <= 1'b1;
    end else if (load_now) begin
      txbuf_full_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Baud generator, running only while a frame is in flight.
  assign run = (state_q == UMS_ST_SHIFT);

  ums_baud #(
    .DIV_W (DIV_W)
  ) u_baud (
    .mclk_in    (mclk_in),
    .resetn_in  (resetn_in),
    .run_in     (run),
    .divisor_in (baud_divisor_in),
    .tick_out   (tick)
  );

  // ==========================================================================
  // Edge roles. Even half counts end in a leading edge, odd ones in a
  // trailing edge; phase select swaps which of them sets up and samples.
  assign leading    = !half_q[0];
  assign setup_now  = run && tick && (control_in.clock_phase_select ? leading : (!leading && half_q != `UMS_HALF_LAST));
  assign sample_now = run && tick && (control_in.clock_phase_select ? !leading : leading);
  assign frame_end  = run && tick && (half_q == `UMS_HALF_LAST);

  // ==========================================================================
  // Sequencer.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= UMS_ST_IDLE;
    end else begin
      unique case (state_q)
        UMS_ST_IDLE: begin
          if (load_now) begin
            state_q <= UMS_ST_SHIFT;
          end
        end
        UMS_ST_SHIFT: begin
          if (frame_end) begin
            state_q <= UMS_ST_DONE;
          end
        end
        UMS_ST_DONE: begin
          state_q <= UMS_ST_IDLE;
        end
        default: begin
          state_q <= UMS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      half_q <= 4'h0;
    end else if (load_now) begin
      half_q <= 4'h0;
    end else if (run && tick) begin
      half_q <= half_q + 4'h1;
    end
  end

  // ==========================================================================
  // Transfer clock. It rests at the polarity level between frames.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sck_q <= 1'b0;
    end else if (run && tick) begin
      sck_q <= !sck_q;
    end else if (state_q != UMS_ST_SHIFT) begin
      sck_q <= control_in.clock_polarity_select;
    end
  end

  // ==========================================================================
  // Transmit shifter. With phase zero the first bit is set up at load.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shift_q <= `UMS_BYTE_RESET;
      mosi_q  <= 1'b1;
    end else if (load_now) begin
      if (!control_in.clock_phase_select) begin
        mosi_q  <= lsb_first ? txbuf_q[0] : txbuf_q[7];
        shift_q <= lsb_first ? {1'b0, txbuf_q[7:1]} : {txbuf_q[6:0], 1'b0};
      end else begin
        shift_q <= txbuf_q;
      end
    end else if (setup_now) begin
      mosi_q  <= lsb_first ? shift_q[0] : shift_q[7];
      shift_q <= lsb_first ? {1'b0, shift_q[7:1]} : {shift_q[6:0], 1'b0};
    end else if (state_q == UMS_ST_IDLE && !txbuf_full_q) begin
      mosi_q  <= 1'b1;
    end
  end

  // ==========================================================================
  // Receive shifter.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_shift_q <= `UMS_BYTE_RESET;
    end else if (sample_now && control_in.receiver_enable) begin
      rx_shift_q <= lsb_first ? {sin_sync_q, rx_shift_q[7:1]} : {rx_shift_q[6:0], sin_sync_q};
    end
  end

  // ==========================================================================
  // Receive buffer. A full buffer refuses the push, so the newest byte is
  // the one lost and the unread bytes stay intact.
  assign rx_push  = (state_q == UMS_ST_DONE) && control_in.receiver_enable && rx_ready;
  assign rx_flush = !control_in.receiver_enable;
  assign rx_pop   = data_rd_in;

  ums_fifo #(
    .WIDTH (8),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .mclk_in       (mclk_in),
    .resetn_in     (resetn_in),
    .flush_in      (rx_flush),
    .in_valid_in   (rx_push),
    .in_ready_out  (rx_ready),
    .in_data_in    (rx_shift_q),
    .out_valid_out (rx_valid),
    .out_ready_in  (rx_pop),
    .out_data_out  (rx_head)
  );

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_byte_q <= `UMS_BYTE_RESET;
    end else if (data_rd_in && rx_valid && !rx_flush) begin
      rd_byte_q <= rx_head;
    end
  end

  // ==========================================================================
  // Status flags. Transmit-complete is set when a frame ends with nothing
  // queued; a set in the same cycle as a clear wins.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      txc_q <= 1'b0;
    end else if (state_q == UMS_ST_DONE && !txbuf_full_q) begin
      txc_q <= 1'b1;
    end else if (tx_complete_clr_in) begin
      txc_q <= 1'b0;
    end
  end

  // Receive-complete trails the buffer level by one cycle, which is the
  // price of driving every output from a flip-flop.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rxc_q  <= 1'b0;
      udre_q <= 1'b1;
    end else begin
      rxc_q  <= rx_valid && !rx_flush;
      udre_q <= !txbuf_full_q;
    end
  end

  // ==========================================================================
  // Pin ownership.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      serial_out_pin_out        <= 1'b0;
      serial_out_pin_oe_out     <= 1'b0;
      transfer_clock_pin_out    <= 1'b0;
      transfer_clock_pin_oe_out <= 1'b0;
      serial_in_override_out    <= 1'b0;
    end else begin
      serial_out_pin_out        <= tx_on_q ? mosi_q : port_out_value_in;
      serial_out_pin_oe_out     <= tx_on_q ? 1'b1 : port_out_oe_in;
      transfer_clock_pin_out    <= sck_q;
      transfer_clock_pin_oe_out <= tx_on_q;
      serial_in_override_out    <= spi_mode && control_in.receiver_enable;
    end
  end

  // ==========================================================================
  // Outputs.
  assign data_rd_byte_out                  = rd_byte_q;
  assign status_out.receive_complete_flag  = rxc_q;
  assign status_out.transmit_complete_flag = txc_q;
  assign status_out.data_empty_flag        = udre_q;
  assign status_out.frame_error_flag       = 1'b0;
  assign status_out.overrun_flag           = 1'b0;
  assign status_out.parity_error_flag      = 1'b0;

endmodule : ums_spi_master

/* File: verif/ums_properties.sv */
`timescale 1ns/10ps
module ums_properties
  import ums_pkg::*;
#(
  parameter int DIV_W    = 12,
  parameter int RX_DEPTH = 8
) (
  input wire logic             mclk_in,
  input wire logic             resetn_in,
  input wire ums_ctrl_t        control_in,
  input wire logic [DIV_W-1:0] baud_divisor_in,
  input wire logic             data_wr_in,
  input wire logic [7:0]       data_wr_byte_in,
  input wire logic             data_rd_in,
  input wire logic             tx_complete_clr_in,
  input wire logic             port_out_value_in,
  input wire logic             port_out_oe_in,
  input wire logic             serial_in_pin_in,
  input wire logic [7:0]       data_rd_byte_out,
  input wire ums_status_t      status_out,
  input wire logic             serial_out_pin_out,
  input wire logic             serial_out_pin_oe_out,
  input wire logic             transfer_clock_pin_out,
  input wire logic             transfer_clock_pin_oe_out,
  input wire logic             serial_in_override_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  // ==========
  // Assertions.
  property p_err_zero;
    {status_out.frame_error_flag, status_out.overrun_flag, status_out.parity_error_flag} == 3'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error flags not zero");
  property p_pins_together;
    transfer_clock_pin_oe_out |-> serial_out_pin_oe_out;
  endproperty
  a_pins_together: assert property (p_pins_together)
    else $error("serial out not driven with clock");
  // The port values are compared one cycle back because the pins are registered after the port inputs.
  property p_port_follow;
    $past(resetn_in, 2) && !transfer_clock_pin_oe_out && !$past(transfer_clock_pin_oe_out)
      |-> serial_out_pin_out == $past(port_out_value_in) && serial_out_pin_oe_out == $past(port_out_oe_in);
  endproperty
  a_port_follow: assert property (p_port_follow)
    else $error("serial out pin not following port");
  property p_rx_override;
    $past(resetn_in) |-> serial_in_override_out ==
      ($past(control_in.mode_select) == 2'h3 && $past(control_in.receiver_enable));
  endproperty
  a_rx_override: assert property (p_rx_override)
    else $error("serial in override wrong");
  property p_mode_gate;
    !transfer_clock_pin_oe_out && control_in.mode_select != 2'h3 && $past(control_in.mode_select) != 2'h3
      |=> !transfer_clock_pin_oe_out;
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("transmitter started outside spi mode");
  property p_hold_busy;
    transfer_clock_pin_oe_out && !status_out.data_empty_flag |=> transfer_clock_pin_oe_out;
  endproperty
  a_hold_busy: assert property (p_hold_busy)
    else $error("transmitter released with data pending");
  property p_load;
    data_wr_in && control_in.transmitter_enable && $past(control_in.transmitter_enable)
      && transfer_clock_pin_oe_out && status_out.data_empty_flag |-> ##[1:3] !status_out.data_empty_flag;
  endproperty
  a_load: assert property (p_load)
    else $error("write not taken into buffer");
  property p_no_clock;
    !transfer_clock_pin_oe_out [*2] |-> $stable(transfer_clock_pin_out);
  endproperty
  a_no_clock: assert property (p_no_clock)
    else $error("clock moved with transmitter off");
  property p_rx_done;
    $rose(status_out.receive_complete_flag) |-> serial_in_override_out;
  endproperty
  a_rx_done: assert property (p_rx_done)
    else $error("receive flag without receiver");

  c_rx: cover property ($rose(status_out.receive_complete_flag));
  c_off: cover property ($fell(transfer_clock_pin_oe_out));
  c_wr: cover property (data_wr_in && transfer_clock_pin_oe_out && status_out.data_empty_flag);
endmodule : ums_properties

bind ums_spi_master ums_properties #(.DIV_W(DIV_W), .RX_DEPTH(RX_DEPTH)) chk (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .control_in(control_in), .baud_divisor_in(baud_divisor_in),
  .data_wr_in(data_wr_in), .data_wr_byte_in(data_wr_byte_in), .data_rd_in(data_rd_in),
  .tx_complete_clr_in(tx_complete_clr_in), .port_out_value_in(port_out_value_in),
  .port_out_oe_in(port_out_oe_in), .serial_in_pin_in(serial_in_pin_in), .data_rd_byte_out(data_rd_byte_out),
  .status_out(status_out), .serial_out_pin_out(serial_out_pin_out), .serial_out_pin_oe_out(serial_out_pin_oe_out),
  .transfer_clock_pin_out(transfer_clock_pin_out), .transfer_clock_pin_oe_out(transfer_clock_pin_oe_out),
  .serial_in_override_out(serial_in_override_out));

/* File: verif/ums_spi_slave.sv */
`timescale 1ns/10ps
module ums_spi_slave (
  input  wire logic  sck_in,
  input  wire logic  mosi_in,
  input  wire logic  cpol_in,
  input  wire logic  cpha_in,
  input  wire logic  lsb_in,
  output logic       miso_out,
  output logic       done_out,
  output logic [7:0] rx_out
);
  logic [7:0] tx_q [$];
  logic [7:0] sh   = 8'h00;
  logic       have = 1'b0;
  int         cnt  = 0;
  int         frames = 0;

  // ==========
  // Reply queue, filled by the bench before each frame.
  task automatic push(input logic [7:0] v);
    tx_q.push_back(v);
    if (!have) begin
      sh = tx_q.pop_front();
      have = 1'b1;
    end
  endtask : push

  // ==========
  // There is no select line, so frames are counted purely by sampling edges.
  initial done_out = 1'b0;
  assign miso_out = lsb_in ? sh[cnt] : sh[7-cnt];
  always @(sck_in) begin
    if ((sck_in != cpol_in) != cpha_in) begin
      rx_out = lsb_in ? {mosi_in, rx_out[7:1]} : {rx_out[6:0], mosi_in};
      cnt++;
      if (cnt == 8) begin
        cnt = 0;
        frames++;
        have = tx_q.size() > 0;
        sh = have ? tx_q.pop_front() : ~sh;
        done_out = 1'b1;
        #1 done_out = 1'b0;
      end
    end
  end
endmodule : ums_spi_slave

/* File: verif/ums_spi_master_tb.sv */
`timescale 1ns/10ps
module ums_spi_master_tb
  import ums_pkg::*;
;
  localparam int LIMIT = 40000;
  logic        mclk_in;
  logic        resetn_in = 1'b0;
  ums_ctrl_t   ctrl = '0;
  logic [11:0] div = 12'h000;
  logic        wr_en = 1'b0;
  logic [7:0]  wr_byte = 8'h00;
  logic        rd_en = 1'b0;
  logic        tc_clr = 1'b0;
  logic        port_v = 1'b0;
  logic        port_oe = 1'b0;
  logic        rd_arm = 1'b0;
  logic        miso, mosi, mosi_oe, sck, sck_oe, rx_ovr, s_done;
  logic [7:0]  rd_byte, s_rx, b;
  ums_status_t st;
  logic [7:0]  exp_mosi [$];
  logic [7:0]  exp_miso [$];
  int          err_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  ums_spi_master uut (.mclk_in(mclk_in), .resetn_in(resetn_in), .control_in(ctrl), .baud_divisor_in(div),
    .data_wr_in(wr_en), .data_wr_byte_in(wr_byte), .data_rd_in(rd_en), .tx_complete_clr_in(tc_clr),
    .port_out_value_in(port_v), .port_out_oe_in(port_oe), .serial_in_pin_in(miso), .data_rd_byte_out(rd_byte),
    .status_out(st), .serial_out_pin_out(mosi), .serial_out_pin_oe_out(mosi_oe), .transfer_clock_pin_out(sck),
    .transfer_clock_pin_oe_out(sck_oe), .serial_in_override_out(rx_ovr));
  ums_spi_slave slv (.sck_in(sck), .mosi_in(mosi), .cpol_in(ctrl.clock_polarity_select),
    .cpha_in(ctrl.clock_phase_select), .lsb_in(ctrl.bit_order_select), .miso_out(miso), .done_out(s_done),
    .rx_out(s_rx));

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  // ==========
  // Checking and verdict.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge mclk_in) begin
    rd_arm <= rd_en;
    port_v <= 1'($urandom);
    port_oe <= 1'($urandom);
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      give_verdict();
    end
  end
  always @(negedge mclk_in) if (rd_arm) check(rd_byte, exp_miso.pop_front());
  always @(posedge s_done) check(s_rx, exp_mosi.pop_front());

  // ==========
  // Bus tasks; wr, rd and drain return at a falling edge so flags are read settled; reply waits for no edge.
  task automatic wr(input logic [7:0] v, input logic go);
    while (st.data_empty_flag !== 1'b1) @(negedge mclk_in);
    @(posedge mclk_in);
    wr_byte <= v;
    wr_en <= 1'b1;
    tc_clr <= 1'b1;
    if (go) exp_mosi.push_back(v);
    @(posedge mclk_in);
    wr_en <= 1'b0;
    tc_clr <= 1'b0;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask : wr

  task automatic rd();
    while (st.receive_complete_flag !== 1'b1) @(negedge mclk_in);
    @(posedge mclk_in);
    rd_en <= 1'b1;
    @(posedge mclk_in);
    rd_en <= 1'b0;
    repeat (2) @(negedge mclk_in);
  endtask : rd

  task automatic drain();
    while (st.transmit_complete_flag !== 1'b1) @(negedge mclk_in);
  endtask : drain

  task automatic reply(input logic keep);
    b = 8'($urandom);
    slv.push(b);
    if (keep) exp_miso.push_back(b);
  endtask : reply

  // ==========
  // Main sequence.
  initial begin
    void'($urandom(32'hffee_2440));
    repeat (16) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (2) @(negedge mclk_in);
    check({2'h0, st}, 8'h08);
    wr(8'h5a, 1'b0);
    repeat (200) @(negedge mclk_in);
    check({7'h00, sck_oe}, 8'h00);
    check(8'(slv.frames), 8'h00);
    @(posedge mclk_in);
    div <= 12'h000;
    ctrl.mode_select <= 2'h3;
    ctrl.transmitter_enable <= 1'b1;
    ctrl.receiver_enable <= 1'b1;
    repeat (4) @(posedge mclk_in);
    div <= 12'h003;
    repeat (2) @(negedge mclk_in);
    check({5'h00, mosi_oe, sck_oe, rx_ovr}, 8'h07);
    // Polarity only changes together with phase 0, so the idle-level step is never a sampling edge.
    for (int m = 0; m < 8; m++) begin
      @(posedge mclk_in);
      {ctrl.bit_order_select, ctrl.clock_polarity_select, ctrl.clock_phase_select} <= 3'(m);
      repeat (4) @(negedge mclk_in);
      reply(1'b1);
      wr(8'($urandom), 1'b1);
      rd();
    end
    @(posedge mclk_in);
    {ctrl.bit_order_select, ctrl.clock_polarity_select, ctrl.clock_phase_select} <= 3'h0;
    repeat (4) @(negedge mclk_in);
    for (int i = 0; i < 10; i++) reply(i < 8);
    repeat (10) wr(8'($urandom), 1'b1);
    drain();
    repeat (8) rd();
    repeat (4) @(negedge mclk_in);
    check({7'h00, st.receive_complete_flag}, 8'h00);
    repeat (2) reply(1'b1);
    repeat (2) wr(8'($urandom), 1'b1);
    @(posedge mclk_in);
    ctrl.transmitter_enable <= 1'b0;
    drain();
    repeat (2) rd();
    repeat (4) @(negedge mclk_in);
    check({7'h00, sck_oe}, 8'h00);
    wr(8'h3c, 1'b0);
    repeat (200) @(negedge mclk_in);
    check(8'(slv.frames), 8'h14);
    @(posedge mclk_in);
    ctrl.receiver_enable <= 1'b0;
    ctrl.transmitter_enable <= 1'b1;
    repeat (4) @(negedge mclk_in);
    reply(1'b0);
    wr(8'($urandom), 1'b1);
    drain();
    repeat (4) @(negedge mclk_in);
    check({6'h00, rx_ovr, st.receive_complete_flag}, 8'h00);
    @(posedge mclk_in);
    ctrl.transmitter_enable <= 1'b0;
    repeat (4) @(posedge mclk_in);
    ctrl.mode_select <= 2'h1;
    @(posedge mclk_in);
    ctrl.transmitter_enable <= 1'b1;
    repeat (2) @(negedge mclk_in);
    wr(8'hc3, 1'b0);
    repeat (200) @(negedge mclk_in);
    check({7'h00, sck_oe}, 8'h00);
    check(8'(slv.frames), 8'h15);
    give_verdict();
  end
endmodule : ums_spi_master_tb
